// >>> rtl/fcd_pkg.sv
// Package of constants and types for the flash command decoder
package fcd_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] STATUS_OFS  = 6'h00;
  localparam logic [5:0] COMMAND_OFS = 6'h04;
  localparam logic [5:0] PARAM0_OFS  = 6'h08;
  localparam logic [5:0] PPROT_OFS   = 6'h18;
  localparam logic [5:0] DPROT_OFS   = 6'h1C;
  localparam logic [5:0] MARGIN_OFS  = 6'h20;
  localparam logic [5:0] STATE_OFS   = 6'h24;
  localparam int         NUM_PARAMS  = 4;

  // ==========================================================================
  // Field positions
  localparam int ST_CCF_BIT     = 7;
  localparam int ST_ACCESS_ERROR_FLAG_BIT  = 5;
  localparam int ST_PVIOL_BIT   = 4;
  localparam int ST_VFAIL_BIT   = 1;
  localparam int ST_UNSEC_BIT   = 0;
  localparam int PP_LOW_BIT     = 0;
  localparam int PP_HIGH_BIT    = 1;
  localparam int PP_OPEN_BIT    = 2;
  localparam int DP_OPEN_BIT    = 0;
  localparam int CMD_IDX_LSB    = 8;

  // ==========================================================================
  // Reset values
  localparam logic [2:0]  PPROT_RST = 3'h0;
  localparam logic        DPROT_RST = 1'b0;
  localparam logic [15:0] PARAM_RST = 16'h0000;
  localparam logic [1:0]  MARGIN_RST = 2'h0;

  // Global address [17:16] that selects the data-flash block
  localparam logic [1:0] DF_BLOCK_SEL = 2'h1;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_EV_ALL   = 8'h01;
  localparam logic [7:0] CMD_EV_BLK   = 8'h02;
  localparam logic [7:0] CMD_EV_PSECT = 8'h03;
  localparam logic [7:0] CMD_RD_ONCE  = 8'h04;
  localparam logic [7:0] CMD_PGM_P    = 8'h06;
  localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERS_ALL  = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK  = 8'h09;
  localparam logic [7:0] CMD_ERS_PSEC = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_KEY_CHK  = 8'h0C;
  localparam logic [7:0] CMD_USR_MRG  = 8'h0D;
  localparam logic [7:0] CMD_FLD_MRG  = 8'h0E;
  localparam logic [7:0] CMD_EV_DSECT = 8'h10;
  localparam logic [7:0] CMD_PGM_D    = 8'h11;
  localparam logic [7:0] CMD_ERS_DSEC = 8'h12;

  // ==========================================================================
  // One-hot operation positions and target positions
  typedef enum logic [3:0] {
    OP_EV_ALL, OP_EV_BLK, OP_EV_PSECT, OP_RD_ONCE, OP_PGM_P, OP_PGM_ONCE,
    OP_ERS_ALL, OP_ERS_BLK, OP_ERS_PSEC, OP_UNSECURE, OP_KEY_CHK,
    OP_USR_MRG, OP_FLD_MRG, OP_EV_DSECT, OP_PGM_D, OP_ERS_DSEC
  } fcd_op_idx_t;
  localparam int NUM_OPS = 16;
  localparam int TGT_PF  = 0;
  localparam int TGT_DF  = 1;

  // Launched command handed to the execution sequencer
  typedef struct packed {
    logic [NUM_OPS-1:0] op_onehot;
    logic [1:0]         target_onehot;
    logic [2:0]         last_index;
    logic [63:0]        params;
  } fcd_launch_t;

  // Completion report from the execution sequencer
  typedef struct packed {
    logic done;
    logic verify_fail;
    logic unsecured;
  } fcd_result_t;

endpackage : fcd_pkg

// >>> rtl/fcd_code_map.sv
// Maps a command code to its one-hot operation
`timescale 1ns/10ps
module fcd_code_map (
  // Command code in
  input  wire logic [7:0]              code,
  // Decoded operation out
  output logic      [fcd_pkg::NUM_OPS-1:0] op_onehot,
  output logic                             valid
);

  always_comb begin
    op_onehot = '0;
    valid     = 1'b1;
    case (code)
      fcd_pkg::CMD_EV_ALL:   op_onehot[fcd_pkg::OP_EV_ALL]   = 1'b1;
      fcd_pkg::CMD_EV_BLK:   op_onehot[fcd_pkg::OP_EV_BLK]   = 1'b1;
      fcd_pkg::CMD_EV_PSECT: op_onehot[fcd_pkg::OP_EV_PSECT] = 1'b1;
      fcd_pkg::CMD_RD_ONCE:  op_onehot[fcd_pkg::OP_RD_ONCE]  = 1'b1;
      fcd_pkg::CMD_PGM_P:    op_onehot[fcd_pkg::OP_PGM_P]    = 1'b1;
      fcd_pkg::CMD_PGM_ONCE: op_onehot[fcd_pkg::OP_PGM_ONCE] = 1'b1;
      fcd_pkg::CMD_ERS_ALL:  op_onehot[fcd_pkg::OP_ERS_ALL]  = 1'b1;
      fcd_pkg::CMD_ERS_BLK:  op_onehot[fcd_pkg::OP_ERS_BLK]  = 1'b1;
      fcd_pkg::CMD_ERS_PSEC: op_onehot[fcd_pkg::OP_ERS_PSEC] = 1'b1;
      fcd_pkg::CMD_UNSECURE: op_onehot[fcd_pkg::OP_UNSECURE] = 1'b1;
      fcd_pkg::CMD_KEY_CHK:  op_onehot[fcd_pkg::OP_KEY_CHK]  = 1'b1;
      fcd_pkg::CMD_USR_MRG:  op_onehot[fcd_pkg::OP_USR_MRG]  = 1'b1;
      fcd_pkg::CMD_FLD_MRG:  op_onehot[fcd_pkg::OP_FLD_MRG]  = 1'b1;
      fcd_pkg::CMD_EV_DSECT: op_onehot[fcd_pkg::OP_EV_DSECT] = 1'b1;
      fcd_pkg::CMD_PGM_D:    op_onehot[fcd_pkg::OP_PGM_D]    = 1'b1;
      fcd_pkg::CMD_ERS_DSEC: op_onehot[fcd_pkg::OP_ERS_DSEC] = 1'b1;
      default:               valid = 1'b0;
    endcase
  end

endmodule : fcd_code_map

// >>> rtl/fcd_launch_check.sv
// Launch checks: target selection, protection, mode and one-time lock
`timescale 1ns/10ps
module fcd_launch_check (
  // Decoded command
  input  wire logic [fcd_pkg::NUM_OPS-1:0] op_onehot,
  input  wire logic [1:0]                  block_sel,
  // Protection and state
  input  wire logic                        low_region_protect_disable,
  input  wire logic                        high_region_protect_disable,
  input  wire logic                        pflash_open_protect,
  input  wire logic                        dflash_open_protect,
  input  wire logic                        special_mode,
  input  wire logic                        once_used,
  // Verdict
  output logic      [1:0]                  target_onehot,
  output logic                             prot_fail,
  output logic                             access_fail
);

  logic pf_all_open;
  logic df_sel;

  always_comb begin
    pf_all_open = low_region_protect_disable & high_region_protect_disable &
                  pflash_open_protect;
    df_sel      = (block_sel == fcd_pkg::DF_BLOCK_SEL);
    target_onehot = 2'h0;
    prot_fail     = 1'b0;
    access_fail   = 1'b0;
    if (op_onehot[fcd_pkg::OP_EV_ALL] | op_onehot[fcd_pkg::OP_ERS_ALL] |
        op_onehot[fcd_pkg::OP_UNSECURE] | op_onehot[fcd_pkg::OP_KEY_CHK]) begin
      target_onehot = 2'h3;
    end else if (op_onehot[fcd_pkg::OP_EV_BLK] |
                 op_onehot[fcd_pkg::OP_ERS_BLK] |
                 op_onehot[fcd_pkg::OP_USR_MRG] |
                 op_onehot[fcd_pkg::OP_FLD_MRG]) begin
      target_onehot[fcd_pkg::TGT_DF] = df_sel;
      target_onehot[fcd_pkg::TGT_PF] = ~df_sel;
    end else if (op_onehot[fcd_pkg::OP_EV_DSECT] |
                 op_onehot[fcd_pkg::OP_PGM_D] |
                 op_onehot[fcd_pkg::OP_ERS_DSEC]) begin
      target_onehot[fcd_pkg::TGT_DF] = 1'b1;
    end else begin
      target_onehot[fcd_pkg::TGT_PF] = 1'b1;
    end
    if (op_onehot[fcd_pkg::OP_ERS_ALL] &
        ~(pf_all_open & dflash_open_protect)) begin
      prot_fail = 1'b1;
    end
    if (op_onehot[fcd_pkg::OP_ERS_BLK] & ~df_sel & ~pf_all_open) begin
      prot_fail = 1'b1;
    end
    if (op_onehot[fcd_pkg::OP_ERS_BLK] & df_sel & ~dflash_open_protect) begin
      prot_fail = 1'b1;
    end
    if ((op_onehot[fcd_pkg::OP_FLD_MRG] | op_onehot[fcd_pkg::OP_ERS_ALL] |
         op_onehot[fcd_pkg::OP_UNSECURE]) & ~special_mode) begin
      access_fail = 1'b1;
    end
    if (op_onehot[fcd_pkg::OP_PGM_ONCE] & once_used) begin
      access_fail = 1'b1;
    end
  end

endmodule : fcd_launch_check

// >>> rtl/fcd_flash_command_decoder.sv
// Flash command decoder: registers, launch checks and dispatch
// Function
// - Code 01 verifies all program-flash and data-flash blocks erased.
// - Code 02 verifies one selected program- or data-flash block erased.
// - Code 03 verifies a counted run of program-flash locations erased.
// - Code 04 reads back the 64 byte one-time information field.
// - Code 06 programs one phrase into program flash at given address.
// - Code 07 programs the 64 byte one-time field, only once until reset.
// - Code 08 erases everything only with all four protection bits open.
// - Code 09 on program flash needs low, high and open bits set.
// - Code 09 on data flash needs the data-flash open bit set.
// - Code 0A erases the addressed program-flash sector.
// - Code 0B unsecures by erasing all blocks then verifying them.
// - Code 0C unsecures by comparing supplied keys with stored keys.
// - Code 0D sets user margin level for program or data flash.
// - Code 0E sets field margin level, accepted in special mode only.
// - Code 10 verifies a counted run of data-flash locations erased.
// - Code 11 programs one to four words into data flash.
// - Code 12 erases the addressed data-flash sector.
// - Invalid code sets access error and the command is not run.
// - Writing one to complete flag launches; flag stays clear until done, or one cycle only for margin codes 0D and 0E.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module fcd_flash_command_decoder (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Operating mode
  input  wire logic                 special_mode,
  // Execution sequencer
  output fcd_pkg::fcd_launch_t      launch,
  output logic                      op_start,
  input  wire fcd_pkg::fcd_result_t result
);

  // ==========================================================================
  // Bus handshake
  logic        ack_reg;
  logic        req;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] wdata;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  // Writes land only in the cycle that waitrequest is low
  assign wr_en           = avs_write & ack_reg;
  assign rd_en           = avs_read & ~ack_reg;

  // Lanes not enabled are masked to zero, so they write zeros
  always_comb begin
    wdata = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (avs_byteenable[i]) begin
        wdata[i*8 +: 8] = avs_writedata[i*8 +: 8];
      end
    end
  end

  // One wait cycle per access, then a single-cycle release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ==========================================================================
  // State flags and storage
  logic                      command_complete_flag;
  logic                      access_error_flag;
  logic                      prot_violation_flag;
  logic                      verify_fail_reg;
  logic                      unsecured_reg;
  logic                      once_used_reg;
  logic [7:0]                flash_command_code;
  logic [2:0]                param_index_reg;
  logic [15:0]               command_parameter_reg [fcd_pkg::NUM_PARAMS];
  logic [2:0]                pflash_protection_reg;
  logic                      dflash_protection_reg;
  logic [1:0]                pf_margin_reg;
  logic [1:0]                df_margin_reg;
  logic                      pending_once_reg;

  logic                      low_region_protect_disable;
  logic                      high_region_protect_disable;
  logic                      pflash_open_protect;
  logic                      dflash_open_protect;

  assign low_region_protect_disable  =
    pflash_protection_reg[fcd_pkg::PP_LOW_BIT];
  assign high_region_protect_disable =
    pflash_protection_reg[fcd_pkg::PP_HIGH_BIT];
  assign pflash_open_protect = pflash_protection_reg[fcd_pkg::PP_OPEN_BIT];
  assign dflash_open_protect = dflash_protection_reg;

  // ==========================================================================
  // Decode and launch checks
  logic [fcd_pkg::NUM_OPS-1:0] dec_op;
  logic                        dec_valid;
  logic [1:0]                  dec_target;
  logic                        chk_prot_fail;
  logic                        chk_access_fail;

  fcd_code_map u_code_map (
    .code      (flash_command_code),
    .op_onehot (dec_op),
    .valid     (dec_valid)
  );

  fcd_launch_check u_launch_check (
    .op_onehot                   (dec_op),
    .block_sel                   (command_parameter_reg[0][1:0]),
    .low_region_protect_disable  (low_region_protect_disable),
    .high_region_protect_disable (high_region_protect_disable),
    .pflash_open_protect         (pflash_open_protect),
    .dflash_open_protect         (dflash_open_protect),
    .special_mode                (special_mode),
    .once_used                   (once_used_reg),
    .target_onehot               (dec_target),
    .prot_fail                   (chk_prot_fail),
    .access_fail                 (chk_access_fail)
  );

  // Launch request: write-one to the complete flag while it is set
  logic launch_req;
  logic launch_ok;
  logic launch_err;
  logic launch_pviol;
  logic margin_op;
  logic margin_op_reg;

  assign launch_req = wr_en & (avs_address == fcd_pkg::STATUS_OFS) &
                      wdata[fcd_pkg::ST_CCF_BIT] & command_complete_flag;
  // Pending errors must be cleared before a new launch is honoured
  assign launch_err   = ~dec_valid | chk_access_fail | access_error_flag |
                        prot_violation_flag;
  assign launch_pviol = dec_valid & chk_prot_fail;
  assign launch_ok    = launch_req & ~launch_err & ~launch_pviol;
  assign margin_op    = dec_op[fcd_pkg::OP_USR_MRG] |
                        dec_op[fcd_pkg::OP_FLD_MRG];

  // ==========================================================================
  // Command code and parameter registers
  logic cfg_open;
  assign cfg_open = wr_en & command_complete_flag;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_command_code <= 8'h00;
      param_index_reg    <= 3'h0;
    end else if (cfg_open & (avs_address == fcd_pkg::COMMAND_OFS)) begin
      flash_command_code <= wdata[7:0];
      param_index_reg    <= wdata[fcd_pkg::CMD_IDX_LSB +: 3];
    end
  end

  genvar g;
  generate
    for (g = 0; g < fcd_pkg::NUM_PARAMS; g++) begin : g_param
      localparam logic [5:0] OFS = 6'(fcd_pkg::PARAM0_OFS + 4 * g);
      // Writes while a command runs are dropped
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          command_parameter_reg[g] <= fcd_pkg::PARAM_RST;
        end else if (cfg_open & (avs_address == OFS)) begin
          command_parameter_reg[g] <= wdata[15:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Protection registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pflash_protection_reg <= fcd_pkg::PPROT_RST;
      dflash_protection_reg <= fcd_pkg::DPROT_RST;
    end else if (cfg_open) begin
      if (avs_address == fcd_pkg::PPROT_OFS) begin
        pflash_protection_reg <= wdata[2:0];
      end
      if (avs_address == fcd_pkg::DPROT_OFS) begin
        dflash_protection_reg <= wdata[fcd_pkg::DP_OPEN_BIT];
      end
    end
  end

  // ==========================================================================
  // Command complete flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      command_complete_flag <= 1'b1;
    end else if (launch_ok) begin
      command_complete_flag <= 1'b0;
    end else if (op_start & margin_op_reg) begin
      command_complete_flag <= 1'b1;
    end else if (~command_complete_flag & ~op_start & result.done) begin
      command_complete_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // Error flags: write one clears, a new error in the same cycle wins
  logic clr_wr;
  assign clr_wr = wr_en & (avs_address == fcd_pkg::STATUS_OFS);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      access_error_flag <= 1'b0;
    end else if (launch_req & launch_err) begin
      access_error_flag <= 1'b1;
    end else if (clr_wr & wdata[fcd_pkg::ST_ACCESS_ERROR_FLAG_BIT]) begin
      access_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prot_violation_flag <= 1'b0;
    end else if (launch_req & ~launch_err & launch_pviol) begin
      prot_violation_flag <= 1'b1;
    end else if (clr_wr & wdata[fcd_pkg::ST_PVIOL_BIT]) begin
      prot_violation_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Dispatch to the sequencer, one cycle after launch

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_start      <= 1'b0;
      margin_op_reg <= 1'b0;
    end else begin
      op_start      <= launch_ok;
      margin_op_reg <= launch_ok & margin_op;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      launch <= '0;
    end else if (launch_ok) begin
      launch.op_onehot     <= dec_op;
      launch.target_onehot <= dec_target;
      launch.last_index    <= param_index_reg;
      launch.params        <= {command_parameter_reg[3],
                               command_parameter_reg[2],
                               command_parameter_reg[1],
                               command_parameter_reg[0]};
    end
  end

  // ==========================================================================
  // Margin levels take effect without the sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_margin_reg <= fcd_pkg::MARGIN_RST;
      df_margin_reg <= fcd_pkg::MARGIN_RST;
    end else if (launch_ok & margin_op) begin
      if (dec_target[fcd_pkg::TGT_DF]) begin
        df_margin_reg <= command_parameter_reg[1][1:0];
      end else begin
        pf_margin_reg <= command_parameter_reg[1][1:0];
      end
    end
  end

  // ==========================================================================
  // One-time field lock, and results of finished commands
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_once_reg <= 1'b0;
      once_used_reg    <= 1'b0;
    end else begin
      if (launch_ok) begin
        pending_once_reg <= dec_op[fcd_pkg::OP_PGM_ONCE];
      end
      // Lock only after the program finished; sticks until reset
      if (pending_once_reg & ~command_complete_flag & ~op_start &
          result.done) begin
        once_used_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      verify_fail_reg <= 1'b0;
      unsecured_reg   <= 1'b0;
    end else if (launch_ok) begin
      verify_fail_reg <= 1'b0;
    end else if (~command_complete_flag & ~op_start & result.done) begin
      verify_fail_reg <= result.verify_fail;
      if (result.unsecured) begin
        unsecured_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read data
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    case (avs_address)
      fcd_pkg::STATUS_OFS: begin
        rdata[fcd_pkg::ST_CCF_BIT]    = command_complete_flag;
        rdata[fcd_pkg::ST_ACCESS_ERROR_FLAG_BIT] = access_error_flag;
        rdata[fcd_pkg::ST_PVIOL_BIT]  = prot_violation_flag;
        rdata[fcd_pkg::ST_VFAIL_BIT]  = verify_fail_reg;
        rdata[fcd_pkg::ST_UNSEC_BIT]  = unsecured_reg;
      end
      fcd_pkg::COMMAND_OFS: begin
        rdata[7:0] = flash_command_code;
        rdata[fcd_pkg::CMD_IDX_LSB +: 3] = param_index_reg;
      end
      6'h08:               rdata[15:0] = command_parameter_reg[0];
      6'h0C:               rdata[15:0] = command_parameter_reg[1];
      6'h10:               rdata[15:0] = command_parameter_reg[2];
      6'h14:               rdata[15:0] = command_parameter_reg[3];
      fcd_pkg::PPROT_OFS:  rdata[2:0]  = pflash_protection_reg;
      fcd_pkg::DPROT_OFS:  rdata[0]    = dflash_protection_reg;
      fcd_pkg::MARGIN_OFS: rdata[3:0]  = {df_margin_reg, pf_margin_reg};
      fcd_pkg::STATE_OFS:  rdata[1:0]  = {special_mode, once_used_reg};
      default:             rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_en) begin
      avs_readdata <= rdata;
    end
  end

endmodule : fcd_flash_command_decoder

// >>> verif/fcd_checker.sv
// Checker of bus timing and launch dispatch for the command decoder
`timescale 1ns/10ps
module fcd_checker (
  // Clock, reset and bus
  input wire logic                 ref_clk,
  input wire logic                 rst_b,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [5:0]           avs_address,
  input wire logic [31:0]          avs_writedata,
  input wire logic                 avs_waitrequest,
  // Mode and dispatch
  input wire logic                 special_mode,
  input wire logic                 op_start,
  input wire fcd_pkg::fcd_launch_t launch
);
  // ==========================================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_wait_one_cycle: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait length");
  a_idle_no_wait: assert property (!(avs_read | avs_write) |->
    !avs_waitrequest) else $error("wait while idle");
  a_start_cause: assert property (op_start |-> $past(avs_write &
    !avs_waitrequest & avs_address == fcd_pkg::STATUS_OFS &
    avs_writedata[7])) else $error("start without launch write");
  a_start_pulse: assert property (op_start |=> !op_start)
    else $error("start longer than one cycle");
  a_op_onehot: assert property (op_start |->
    $onehot(launch.op_onehot) && launch.target_onehot != 2'h0)
    else $error("operation not one-hot");
  a_launch_hold: assert property (!op_start |-> $stable(launch))
    else $error("launch changed without start");
  a_mode_gate: assert property (op_start &&
    (launch.op_onehot[fcd_pkg::OP_FLD_MRG] ||
    launch.op_onehot[fcd_pkg::OP_ERS_ALL]) |-> $past(special_mode))
    else $error("special command in normal mode");
  a_all_target: assert property (op_start &&
    launch.op_onehot[fcd_pkg::OP_EV_ALL] |-> launch.target_onehot == 2'h3)
    else $error("verify all not on both arrays");
  a_df_target: assert property (op_start &&
    launch.op_onehot[fcd_pkg::OP_PGM_D] |-> launch.target_onehot == 2'h2)
    else $error("data program not on data array");
endmodule : fcd_checker

bind fcd_flash_command_decoder fcd_checker fcd_checker_inst (.ref_clk,
  .rst_b, .avs_read, .avs_write, .avs_address, .avs_writedata,
  .avs_waitrequest, .special_mode, .op_start, .launch);

// >>> verif/tb_top.sv
// Testbench for the flash command decoder
`timescale 1ns/10ps
module tb_top;
  // ==========================================================================
  // Signals and tables
  logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic        avs_waitrequest, op_start, special_mode = 1'b1;
  fcd_pkg::fcd_launch_t launch;
  fcd_pkg::fcd_result_t result = '0;
  int          mismatches = 0, n_tests = 0, cycles = 0;
  logic [7:0]  codes [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12};
  logic [1:0]  tgts [16] = '{2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3,
    2'h1, 2'h1, 2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
  // Bad launches: {mode, block, data open, program protect[2:0]}
  logic [7:0]  bc [6] = '{8'h05, 8'h07, 8'h0E, 8'h08, 8'h09, 8'h09};
  logic [7:0]  bx [6] = '{8'h2F, 8'h2F, 8'h0F, 8'h2B, 8'h2E, 8'h37};
  logic [7:0]  be [6] = '{8'hA0, 8'hA0, 8'hA0, 8'h90, 8'h90, 8'h90};
  always #50 ref_clk = ~ref_clk;

  fcd_flash_command_decoder fcd_flash_command_decoder_inst (.ref_clk,
    .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .special_mode,
    .launch, .op_start, .result);

  // ==========================================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One idle edge first so no signal is assigned twice in a time step
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task go(input logic [7:0] c, input logic [15:0] p0);
    bus(1'b1, fcd_pkg::COMMAND_OFS, {24'h0, c});
    bus(1'b1, fcd_pkg::PARAM0_OFS, {16'h0, p0});
    bus(1'b1, fcd_pkg::PARAM0_OFS + 6'h04, 32'h2);
    bus(1'b1, fcd_pkg::STATUS_OFS, 32'h80);
    @(negedge ref_clk);
  endtask : go
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(fcd_pkg::STATUS_OFS, 32'h80);
    rd(fcd_pkg::PPROT_OFS, 32'h0);
    rd(6'h3C, 32'h0);
    $display("test reset_values done");
    bus(1'b1, fcd_pkg::PPROT_OFS, 32'h7);
    bus(1'b1, fcd_pkg::DPROT_OFS, 32'h1);
    for (int i = 0; i < 16; i++) begin
      go(codes[i], 16'h0000);
      chk(op_start, 1'b1);
      chk(launch.op_onehot, 16'h1 << i);
      chk(launch.target_onehot, tgts[i]);
      chk(launch.params[31:0], 32'h0002_0000);
      if (i != 11 && i != 12) begin
        rd(fcd_pkg::STATUS_OFS, 32'h00);
        result.done <= 1'b1;
        @(posedge ref_clk);
        result.done <= 1'b0;
      end
      if (i == 11) rd(fcd_pkg::MARGIN_OFS, 32'h2);
      rd(fcd_pkg::STATUS_OFS, 32'h80);
    end
    $display("test decode_all done");
    for (int i = 0; i < 6; i++) begin
      special_mode <= bx[i][5];
      bus(1'b1, fcd_pkg::PPROT_OFS, {29'h0, bx[i][2:0]});
      bus(1'b1, fcd_pkg::DPROT_OFS, {31'h0, bx[i][3]});
      go(bc[i], {15'h0, bx[i][4]});
      chk(op_start, 1'b0);
      rd(fcd_pkg::STATUS_OFS, {24'h0, be[i]});
      bus(1'b1, fcd_pkg::STATUS_OFS, 32'h30);
      rd(fcd_pkg::STATUS_OFS, 32'h80);
    end
    $display("test refusals done");
    report_and_stop();
  end
endmodule : tb_top
